// File: src/nine_bit_uart.sv
// Nine-bit half-duplex UART: register port, transmitter and pin muxing.
// Assumes a same-clock CPU port, an async rx pin and a port-register level.
//
// Operation
// - Frames: start, nine data, stop, generated
// - Ninth bit sent as programmed, no parity
// - Ninth bit kept until rewritten or received
// - Data write starts frame, LSB first
// - Stop done sets tx flag, interrupt
// - Tx flag cleared by zero or data write
// - Writing one to tx flag sets it
// - Idle receiver hunts falling edge, waits bit
// - After stop wait, character goes to buffer
// - Buffer load sets rx flag, interrupt
// - Transmit start aborts ongoing reception
// - Rx flag cleared by zero, settable by one
// - Enables gate interrupts, leave flags alone
// - Data address: write transmits, read buffer
// - Baud code picks divisor, immediate effect
// - Control bit 0 holds the ninth bit
// - Eight states per bit, majority vote
// - Transmit pin output is inverted
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module nine_bit_uart (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic rx_pin,
    input wire logic port_level,
    output logic tx_line,
    output logic tx_output_select,
    output logic tx_irq,
    output logic rx_irq
);
    uart9_pkg::ctrl_t ctrl_q;
    logic [7:0] rx_buf_q;
    logic [uart9_pkg::FRAME_BITS-1:0] tx_shift_q;
    logic tx_active_q;
    logic [2:0] tx_phase_q;
    logic [3:0] tx_bits_q;
    logic rx_meta_q;
    logic rx_sync_q;
    logic tick;
    logic rx_done;
    uart9_pkg::char_t rx_char;
    logic data_wr;
    logic ctrl_wr;
    logic tx_finish;

    // Strobe decode
    assign data_wr = wr_en && addr == uart9_pkg::DATA_ADDR;
    assign ctrl_wr = wr_en && addr == uart9_pkg::CTRL_ADDR;
    assign tx_finish = tx_active_q && tick && tx_phase_q == uart9_pkg::LAST_STATE
        && tx_bits_q == uart9_pkg::LAST_TX_BIT;

    baud_tick #(.CNT_W(10)) u_baud (
        .clk(clk),
        .rst_n(rst_n),
        .baud_sel(ctrl_q.baud),
        .tick(tick)
    );

    rx_frame u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .rx_level(rx_sync_q),
        .abort(tx_active_q),
        .done(rx_done),
        .rx_char(rx_char)
    );

    // Two-flop synchroniser on the asynchronous receive pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_pin;
            rx_sync_q <= rx_meta_q;
        end
    end

    // Enables, baud code and flags reset to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= uart9_pkg::ctrl_t'(uart9_pkg::CTRL_RESET);
        end else begin
            // Enables and baud written without touching flags
            if (ctrl_wr) begin
                ctrl_q.rx_ie <= wdata[uart9_pkg::RX_IE_POS];
                ctrl_q.tx_ie <= wdata[uart9_pkg::TX_IE_POS];
                ctrl_q.baud <= wdata[uart9_pkg::BAUD_LSB_POS +: 3];
            end
            // Rx flag: software writes either level, hardware set wins
            if (rx_done) begin
                ctrl_q.rx_ready <= 1'b1;
            end else if (ctrl_wr) begin
                ctrl_q.rx_ready <= wdata[uart9_pkg::RX_READY_POS];
            end
            // Tx flag: zero clears, one sets, data write clears
            if (tx_finish) begin
                ctrl_q.tx_done <= 1'b1;
            end else if (data_wr) begin
                ctrl_q.tx_done <= 1'b0;
            end else if (ctrl_wr) begin
                ctrl_q.tx_done <= wdata[uart9_pkg::TX_DONE_POS];
            end
            // Received ninth bit overrides the programmed one
            if (rx_done) begin
                ctrl_q.ninth <= rx_char.ninth;
            end else if (ctrl_wr) begin
                ctrl_q.ninth <= wdata[uart9_pkg::NINTH_POS];
            end
        end
    end

    // Receive buffer simply overwritten by each character
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf_q <= uart9_pkg::DATA_RESET;
        end else if (rx_done) begin
            rx_buf_q <= rx_char.data;
        end
    end

    // Frame load and bit sequencing
    // A write mid-frame restarts the frame; first bit may run up to one state short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_active_q <= 1'b0;
            tx_shift_q <= '1;
            tx_phase_q <= '0;
            tx_bits_q <= '0;
        end else if (data_wr) begin
            tx_active_q <= 1'b1;
            tx_shift_q <= {1'b1, ctrl_q.ninth, wdata, 1'b0};
            tx_phase_q <= '0;
            tx_bits_q <= '0;
        end else if (tx_active_q && tick) begin
            tx_phase_q <= tx_phase_q + 1'b1;
            if (tx_phase_q == uart9_pkg::LAST_STATE) begin
                tx_shift_q <= {1'b1, tx_shift_q[uart9_pkg::FRAME_BITS-1:1]};
                tx_bits_q <= tx_bits_q + 1'b1;
                // Frame ends after the full stop bit
                if (tx_bits_q == uart9_pkg::LAST_TX_BIT) begin
                    tx_active_q <= 1'b0;
                end
            end
        end
    end

    // Pin mux: inverted serial data while sending, port level otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_line <= 1'b0;
            tx_output_select <= 1'b0;
        end else begin
            tx_output_select <= tx_active_q;
            tx_line <= tx_active_q ? ~tx_shift_q[0] : port_level;
        end
    end

    // Interrupt requests gated by their enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            tx_irq <= ctrl_q.tx_done && ctrl_q.tx_ie;
            rx_irq <= ctrl_q.rx_ready && ctrl_q.rx_ie;
        end
    end

    // Read port; data is valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd_en && addr == uart9_pkg::DATA_ADDR) begin
            rdata <= rx_buf_q;
        end else if (rd_en && addr == uart9_pkg::CTRL_ADDR) begin
            rdata <= ctrl_q;
        end else begin
            rdata <= '0;
        end
    end

    // Read port, frame start and end, flag setting
    a_data_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == uart9_pkg::DATA_ADDR |=> rdata == $past(rx_buf_q))
        else $error("data read mismatch");

    a_tx_start: assert property (@(posedge clk) disable iff (!rst_n)
        data_wr |=> tx_active_q && !ctrl_q.tx_done ##1 tx_line && tx_output_select)
        else $error("transmit start wrong");

    a_tx_done_set: assert property (@(posedge clk) disable iff (!rst_n)
        tx_finish |=> ctrl_q.tx_done && !tx_active_q ##1 !tx_output_select)
        else $error("tx done not flagged");

    a_rx_ready_set: assert property (@(posedge clk) disable iff (!rst_n)
        rx_done |=> ctrl_q.rx_ready && rx_buf_q == $past(rx_char.data))
        else $error("rx buffer not loaded");

    a_ninth_rx: assert property (@(posedge clk) disable iff (!rst_n)
        rx_done |=> ctrl_q.ninth == $past(rx_char.ninth))
        else $error("ninth bit not updated");

    a_tx_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q.tx_done && ctrl_q.tx_ie |=> tx_irq)
        else $error("tx interrupt missing");

    a_idle_line: assert property (@(posedge clk) disable iff (!rst_n)
        !tx_active_q |=> tx_line == $past(port_level) && !tx_output_select)
        else $error("idle pin not port level");

    a_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
        tx_active_q && tx_bits_q == uart9_pkg::LAST_TX_BIT |=> !tx_line || !tx_active_q)
        else $error("stop bit not high");

    // Helper: baud ticks over one frame, counted apart from the bit counters
    logic [6:0] frame_ticks_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_ticks_q <= '0;
        end else if (data_wr) begin
            frame_ticks_q <= '0;
        end else if (tx_active_q && tick) begin
            frame_ticks_q <= frame_ticks_q + 1'b1;
        end
    end

    // Frame shape, pin polarity, flag and field writes, read port idle level
    a_frame_len: assert property (@(posedge clk) disable iff (!rst_n)
        tx_finish |-> frame_ticks_q == 7'(uart9_pkg::FRAME_BITS * uart9_pkg::OVERSAMPLE - 1))
        else $error("frame length wrong");

    a_select_frame: assert property (@(posedge clk) disable iff (!rst_n)
        tx_active_q |=> tx_output_select)
        else $error("select not held in frame");

    a_tx_invert: assert property (@(posedge clk) disable iff (!rst_n)
        tx_active_q |=> tx_line == !$past(tx_shift_q[0]))
        else $error("tx pin not inverted");

    a_tx_wr_clear: assert property (@(posedge clk) disable iff (!rst_n)
        data_wr && !tx_finish |=> !ctrl_q.tx_done)
        else $error("tx flag not cleared by data write");

    a_tx_sw_write: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr && !tx_finish |=> ctrl_q.tx_done == $past(wdata[uart9_pkg::TX_DONE_POS]))
        else $error("tx flag write ignored");

    a_rx_sw_write: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr && !rx_done |=> ctrl_q.rx_ready == $past(wdata[uart9_pkg::RX_READY_POS]))
        else $error("rx flag write ignored");

    a_rx_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q.rx_ready && ctrl_q.rx_ie |=> rx_irq)
        else $error("rx interrupt missing");

    a_tx_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_q.tx_ie |=> !tx_irq)
        else $error("tx interrupt not masked");

    a_rx_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_q.rx_ie |=> !rx_irq)
        else $error("rx interrupt not masked");

    a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr |=> ctrl_q.rx_ie == $past(wdata[uart9_pkg::RX_IE_POS])
            && ctrl_q.tx_ie == $past(wdata[uart9_pkg::TX_IE_POS]))
        else $error("enable write ignored");

    a_ninth_write: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr && !rx_done |=> ctrl_q.ninth == $past(wdata[uart9_pkg::NINTH_POS]))
        else $error("ninth bit write ignored");

    a_ninth_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_wr && !rx_done |=> $stable(ctrl_q.ninth))
        else $error("ninth bit changed alone");

    a_baud_write: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr |=> ctrl_q.baud == $past(wdata[uart9_pkg::BAUD_LSB_POS +: 3]))
        else $error("baud code write ignored");

    a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == uart9_pkg::CTRL_ADDR |=> rdata == $past(ctrl_q))
        else $error("control read mismatch");

    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !rd_en |=> rdata == 8'h00)
        else $error("read data not idle");

    a_rx_buf_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !rx_done |=> $stable(rx_buf_q))
        else $error("receive buffer changed alone");

endmodule

// File: src/uart9_pkg.sv
// Shared constants and carriers for the nine-bit half-duplex UART.
// Assumes a single 25 MHz system clock and an 8-bit register port.
package uart9_pkg;

    // Register addresses
    localparam logic [7:0] DATA_ADDR = 8'hd6;
    localparam logic [7:0] CTRL_ADDR = 8'hd7;

    // Control/status field positions
    localparam int RX_READY_POS = 7;
    localparam int TX_DONE_POS = 6;
    localparam int RX_IE_POS = 5;
    localparam int TX_IE_POS = 4;
    localparam int BAUD_LSB_POS = 1;
    localparam int NINTH_POS = 0;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Clock divisors per baud code; reserved code 7 falls back to the fastest rate
    localparam int unsigned BAUD_DIV [8] = '{6656, 3328, 1664, 832, 416, 256, 208, 208};

    // Sample states per bit and the three voting states
    localparam int unsigned OVERSAMPLE = 8;
    localparam logic [2:0] LAST_STATE = 3'h7;
    localparam logic [2:0] VOTE_A = 3'h3;
    localparam logic [2:0] VOTE_B = 3'h4;
    localparam logic [2:0] VOTE_C = 3'h5;

    // Frame shape: start, nine data bits, stop
    localparam int FRAME_BITS = 11;
    localparam logic [3:0] LAST_TX_BIT = 4'ha;
    localparam logic [3:0] LAST_RX_BIT = 4'h8;

    typedef struct packed {
        logic rx_ready;
        logic tx_done;
        logic rx_ie;
        logic tx_ie;
        logic [2:0] baud;
        logic ninth;
    } ctrl_t;

    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } char_t;

endpackage

// File: src/baud_tick.sv
// Baud divider producing a one-cycle tick at eight times the bit rate.
// Assumes baud_sel comes from a register on the same clock.
`timescale 1ns/1ps
module baud_tick #(
    parameter int CNT_W = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] baud_sel,
    output logic tick
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] period;

    // Clock cycles per sample state; a new code takes effect at once
    always_comb begin
        period = CNT_W'(uart9_pkg::BAUD_DIV[baud_sel] / uart9_pkg::OVERSAMPLE);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q >= period - 1'b1) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end

    // Shortest period is 26 cycles, so ticks never touch
    a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick [*8]) else $error("baud ticks too close");

endmodule

// File: src/rx_frame.sv
// Receive framer: edge hunt, start wait, nine voted bits, stop wait.
// Assumes rx_level is already synchronised and tick is the 8x rate.
`timescale 1ns/1ps
module rx_frame (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic rx_level,
    input wire logic abort,
    output logic done,
    output uart9_pkg::char_t rx_char
);
    typedef enum logic [1:0] {IDLE, START, DATA, STOP} rx_state_t;

    rx_state_t state_q;
    logic prev_q;
    logic [2:0] phase_q;
    logic [3:0] bit_q;
    logic [2:0] vote_q;
    logic [8:0] shift_q;

    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    // Edge history for falling-edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= rx_level;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= IDLE;
            phase_q <= '0;
            bit_q <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                state_q <= IDLE;
            end else begin
                unique case (state_q)
                    IDLE: begin
                        phase_q <= '0;
                        bit_q <= '0;
                        if (prev_q && !rx_level) begin
                            state_q <= START;
                        end
                    end
                    START: begin
                        if (tick) begin
                            phase_q <= phase_q + 1'b1;
                            if (phase_q == uart9_pkg::LAST_STATE) begin
                                state_q <= DATA;
                            end
                        end
                    end
                    DATA: begin
                        if (tick) begin
                            phase_q <= phase_q + 1'b1;
                            if (phase_q == uart9_pkg::LAST_STATE) begin
                                bit_q <= bit_q + 1'b1;
                                if (bit_q == uart9_pkg::LAST_RX_BIT) begin
                                    state_q <= STOP;
                                end
                            end
                        end
                    end
                    // Stop wait, then hand over; stop level unchecked
                    STOP: begin
                        if (tick) begin
                            phase_q <= phase_q + 1'b1;
                            if (phase_q == uart9_pkg::LAST_STATE) begin
                                state_q <= IDLE;
                                done <= 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vote_q <= '0;
            shift_q <= '0;
        end else if (state_q == DATA && tick) begin
            unique case (phase_q)
                uart9_pkg::VOTE_A: vote_q[0] <= rx_level;
                uart9_pkg::VOTE_B: vote_q[1] <= rx_level;
                uart9_pkg::VOTE_C: vote_q[2] <= rx_level;
                uart9_pkg::LAST_STATE: shift_q <= {maj3(vote_q), shift_q[8:1]};
                default: vote_q <= vote_q;
            endcase
        end
    end

    // LSB arrives first, ninth bit last
    assign rx_char = uart9_pkg::char_t'(shift_q);

    a_rx_abort: assert property (@(posedge clk) disable iff (!rst_n)
        abort |=> state_q == IDLE && !done) else $error("rx not aborted");

endmodule

// File: verification/remote_station.sv
// Remote serial station facing the nine-bit UART pins.
// Assumes the shared system clock and a one-transistor stage that inverts tx_line.
`timescale 1ns/1ps
module remote_station (
    input wire logic clk,
    input wire logic tx_line,
    input wire logic tx_output_select,
    output logic rx_pin
);
    // Line rests high between frames
    initial begin
        rx_pin = 1'b1;
    end

    // Start low, nine bits LSB first, stop high, each bc clocks
    task automatic send(input logic [8:0] c, input int bc);
        int i;
        @(posedge clk);
        rx_pin <= 1'b0;
        repeat (bc) @(posedge clk);
        for (i = 0; i < 9; i++) begin
            rx_pin <= c[i];
            repeat (bc) @(posedge clk);
        end
        rx_pin <= 1'b1;
        repeat (bc) @(posedge clk);
    endtask

    // Mid-bit sampling rides out the short first bit of a free-running divider
    task automatic capture(output logic [10:0] c, input int bc);
        int i;
        i = 0;
        c = 11'h000;
        while (tx_output_select !== 1'b1 && i < 4000) begin
            @(posedge clk);
            i++;
        end
        repeat (bc / 2) @(posedge clk);
        for (i = 0; i < 11; i++) begin
            #1 c[i] = ~tx_line;
            repeat (bc) @(posedge clk);
        end
    endtask
endmodule

// File: verification/half_duplex_nine_bit_uart_tb.sv
// Self-checking bench for the nine-bit UART: register port, both pin directions.
// Assumes remote_station on the pins and a port register held high outside two low cycles in t_reset.
`timescale 1ns/1ps
module half_duplex_nine_bit_uart_tb;
    localparam int BC = 208;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    logic rx_pin;
    logic port_level = 1'b1; // port register high except for two low cycles in t_reset
    logic tx_line;
    logic tx_output_select;
    logic tx_irq;
    logic rx_irq;
    logic [10:0] f;
    logic [7:0] v;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;

    nine_bit_uart nine_bit_uart_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_pin(rx_pin), .port_level(port_level),
        .tx_line(tx_line), .tx_output_select(tx_output_select), .tx_irq(tx_irq), .rx_irq(rx_irq));
    remote_station remote_station_inst (.clk(clk), .tx_line(tx_line),
        .tx_output_select(tx_output_select), .rx_pin(rx_pin));

    // 25 MHz system clock
    initial begin
        forever #20 clk = ~clk;
    end

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 23k cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_frame(input logic [10:0] exp, input logic [10:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error frame expected %h seen %h", exp, got);
        end
    endtask

    // Single-cycle write; ends just after the following edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Data port reads stay separate from writes, never read-modify-write
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic t_reset;
        // Idle pin must follow a low port level too, not just sit high
        @(posedge clk);
        port_level <= 1'b0;
        repeat (2) @(posedge clk);
        port_level <= 1'b1;
        #1 chk_pin("idle low", 1'b0, tx_line);
        rd(uart9_pkg::CTRL_ADDR, v);
        chk_reg("ctrl", uart9_pkg::CTRL_RESET, v);
        rd(uart9_pkg::DATA_ADDR, v);
        chk_reg("data", uart9_pkg::DATA_RESET, v);
        rd(8'h00, v);
        chk_reg("unmapped", 8'h00, v);
        chk_pin("idle tx", 1'b1, tx_line);
        $display("test reset done");
    endtask

    task automatic t_tx;
        wr(uart9_pkg::CTRL_ADDR, 8'h1d);
        fork
            remote_station_inst.capture(f, BC);
            wr(uart9_pkg::DATA_ADDR, 8'ha5);
        join
        chk_frame({1'b1, 1'b1, 8'ha5, 1'b0}, f);
        chk_pin("select", 1'b0, tx_output_select);
        chk_pin("tx_irq", 1'b1, tx_irq);
        rd(uart9_pkg::CTRL_ADDR, v);
        chk_reg("ctrl", 8'h5d, v);
        fork
            remote_station_inst.capture(f, BC);
            begin
                wr(uart9_pkg::DATA_ADDR, 8'h3c);
                rd(uart9_pkg::CTRL_ADDR, v);
                chk_reg("ctrl", 8'h1d, v);
            end
        join
        chk_frame({1'b1, 1'b1, 8'h3c, 1'b0}, f);
        $display("test transmit done");
    endtask

    task automatic t_flags;
        wr(uart9_pkg::CTRL_ADDR, 8'h0c);
        rd(uart9_pkg::CTRL_ADDR, v);
        chk_reg("ctrl", 8'h0c, v);
        wr(uart9_pkg::CTRL_ADDR, 8'h4c);
        chk_pin("tx_irq", 1'b0, tx_irq);
        wr(uart9_pkg::CTRL_ADDR, 8'h5c);
        chk_pin("tx_irq", 1'b1, tx_irq);
        rd(uart9_pkg::CTRL_ADDR, v);
        chk_reg("ctrl", 8'h5c, v);
        wr(uart9_pkg::CTRL_ADDR, 8'hac);
        chk_pin("rx_irq", 1'b1, rx_irq);
        chk_pin("tx_irq", 1'b0, tx_irq);
        wr(uart9_pkg::CTRL_ADDR, 8'h2d);
        chk_pin("rx_irq", 1'b0, rx_irq);
        rd(uart9_pkg::CTRL_ADDR, v);
        chk_reg("ctrl", 8'h2d, v);
        $display("test flags done");
    endtask

    task automatic t_rx;
        int i;
        i = 0;
        remote_station_inst.send({1'b0, 8'h5a}, BC);
        while (rx_irq !== 1'b1 && i < 400) begin
            @(posedge clk);
            #1 i++;
        end
        chk_pin("rx_irq", 1'b1, rx_irq);
        rd(uart9_pkg::DATA_ADDR, v);
        chk_reg("data", 8'h5a, v);
        rd(uart9_pkg::CTRL_ADDR, v);
        chk_reg("ctrl", 8'hac, v);
        remote_station_inst.send({1'b1, 8'hc3}, BC);
        repeat (300) @(posedge clk);
        rd(uart9_pkg::DATA_ADDR, v);
        chk_reg("data", 8'hc3, v);
        rd(uart9_pkg::CTRL_ADDR, v);
        chk_reg("ctrl", 8'had, v);
        $display("test receive done");
    endtask

    task automatic t_abort;
        wr(uart9_pkg::CTRL_ADDR, 8'h2d);
        fork
            remote_station_inst.send({1'b1, 8'h96}, BC);
            begin
                repeat (3 * BC) @(posedge clk);
                fork
                    remote_station_inst.capture(f, BC);
                    wr(uart9_pkg::DATA_ADDR, 8'h4e);
                join
            end
        join
        chk_frame({1'b1, 1'b1, 8'h4e, 1'b0}, f);
        rd(uart9_pkg::CTRL_ADDR, v);
        chk_reg("ctrl", 8'h6d, v);
        $display("test abort done");
    endtask

    // A wrong divisor drifts well past half a bit over the frame
    task automatic t_baud;
        wr(uart9_pkg::CTRL_ADDR, 8'h0a);
        fork
            remote_station_inst.capture(f, 256);
            wr(uart9_pkg::DATA_ADDR, 8'h81);
        join
        chk_frame({1'b1, 1'b0, 8'h81, 1'b0}, f);
        wr(uart9_pkg::CTRL_ADDR, 8'h08);
        fork
            remote_station_inst.capture(f, 416);
            wr(uart9_pkg::DATA_ADDR, 8'h42);
        join
        chk_frame({1'b1, 1'b0, 8'h42, 1'b0}, f);
        // Reserved code runs at the fastest divisor
        wr(uart9_pkg::CTRL_ADDR, 8'h0f);
        fork
            remote_station_inst.capture(f, 208);
            wr(uart9_pkg::DATA_ADDR, 8'h18);
        join
        chk_frame({1'b1, 1'b1, 8'h18, 1'b0}, f);
        $display("test baud done");
    endtask

    // Reset for six cycles; port register held high for a clean idle line
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_tx();
        t_flags();
        t_rx();
        t_abort();
        t_baud();
        stop_test();
    end
endmodule
